// [design/pcef_pkg.sv]
// Package of constants for the port C/E/F pin function multiplexer
// Notes on behaviour
// (R1) Direction bit: clear drives latch, set reads
// (R2) Oscillator enabled takes both oscillator pins
// (R3) Oscillator input pin has digital path off
// (R4) Capture/compare pin outputs or captures by direction
// (R5) Channel two on port C pin 1 if set
// (R6) Channel two on port E bit 7 if clear
// (R7) Serial clock pin outputs or inputs by direction
// (R8) SPI data out and data in pins
// (R9) I2C pins driven by serial port, input mode
// (R10) USART pins carry transmit, receive, clock
// (R11) Software sets sync data pin to input
// (R12) Port E carries memory address/data bits 8-15
// (R13) Memory interface overrides every other function; channel two capture on E7 still samples the pin under memory
// (R14) Memory functions only on the large package
// (R15) Port E bits 0-2 feed slave port controls
// (R16) Analog port is seven bits, bidirectional
// (R17) Analog pins 1-6 serve comparators; 6-3 read gated
// (R18) After reset analog pins 6-1 read zero
// (R19) Priority: memory, then peripheral, then latch
package pcef_pkg;
  localparam int PORT_W      = 8;        // Ports C and E width
  localparam int APORT_W     = 7;        // Analog-shared port width
  localparam int SYNC_STAGES = 2;        // Pin synchroniser depth
  // Port C pin positions
  localparam int PC_OSC_OUT  = 0;
  localparam int PC_OSC_IN   = 1;
  localparam int PC_CAPCOMP_CH1_PIN     = 2;
  localparam int PC_SCK      = 3;
  localparam int PC_SDI      = 4;
  localparam int PC_SDO      = 5;
  localparam int PC_TX       = 6;
  localparam int PC_RX       = 7;
  // Port E positions
  localparam int PE_RD       = 0;
  localparam int PE_WR       = 1;
  localparam int PE_CS       = 2;
  localparam int PE_CAPCOMP_CH2_PIN     = 7;
  // Reset values
  localparam logic [7:0] LATCH_RST = 8'h00;   // Output latches
  localparam logic [7:0] DIR_RST   = 8'hFF;   // All inputs
  localparam logic [6:0] ALAT_RST  = 7'h00;
  localparam logic [6:0] ADIR_RST  = 7'h7F;
  localparam logic [6:0] ANA_RST   = 7'h7E;   // Pins 6..1 analog
  localparam logic [6:0] CMP_RD_MASK = 7'h78; // Pins 6..3
endpackage : pcef_pkg

// [design/pcef_sync.sv]
// Two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module pcef_sync #(
  parameter int W = 8                      // Bits synchronised
) (
  input  wire logic         clk_sys,       // System clock
  input  wire logic         rst_n,         // Sync reset, low
  input  wire logic [W-1:0] async_in,      // Raw pin levels
  output logic      [W-1:0] sync_out       // Synchronised levels
);
  logic [W-1:0] meta;                      // First stage only

  // Second stage is the sole reader of the first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pcef_sync

// [design/pcef_port_bit.sv]
// One generic bidirectional pin cell with override
`timescale 1ns/1ps
module pcef_port_bit (
  input  wire logic latch_bit,             // Output latch value
  input  wire logic dir_bit,               // 1 = input
  input  wire logic ovr_en,                // Peripheral owns output
  input  wire logic ovr_oe,                // Peripheral drive enable
  input  wire logic ovr_dat,               // Peripheral data
  input  wire logic dis,                   // Digital path off
  output logic      pin_o,                 // Pin output value
  output logic      pin_oe                 // Pin drive enable
);
  wire drv_latch = !dir_bit && !dis;       // Latch drives pin

  // (R19) peripheral over latch
  assign pin_o  = ovr_en ? ovr_dat : latch_bit;
  // (R1) clear bit drives
  assign pin_oe = dis ? 1'b0 : (ovr_en ? ovr_oe : drv_latch);
endmodule // pcef_port_bit

// [design/pcef_pin_mux.sv]
// Pin function multiplexer for ports C, E and the analog port
`timescale 1ns/1ps
module pcef_pin_mux #(
  parameter bit HAS_EMI = 1'b1             // Large package variant
) (
  input  wire logic       clk_sys,         // System clock
  input  wire logic       rst_n,           // Sync reset, low
  // Port C latch, direction, pins
  input  wire logic [7:0] pc_latch_wdata,  // Latch write data
  input  wire logic       pc_latch_we,     // Latch write strobe
  input  wire logic [7:0] pc_dir_wdata,    // Direction write data
  input  wire logic       pc_dir_we,       // Direction write strobe
  output logic      [7:0] port_c_pin_read, // Port C read value
  input  wire logic [7:0] pc_pin_i,        // Port C pin levels
  output logic      [7:0] pc_pin_o,        // Port C pin values
  output logic      [7:0] pc_pin_oe,       // Port C drive enables
  // Port E
  input  wire logic [7:0] pe_latch_wdata,  // Latch write data
  input  wire logic       pe_latch_we,     // Latch write strobe
  input  wire logic [7:0] pe_dir_wdata,    // Direction write data
  input  wire logic       pe_dir_we,       // Direction write strobe
  output logic      [7:0] port_e_pin_read, // Port E read value
  input  wire logic [7:0] pe_pin_i,        // Port E pin levels
  output logic      [7:0] pe_pin_o,        // Port E pin values
  output logic      [7:0] pe_pin_oe,       // Port E drive enables
  // Analog-shared port
  input  wire logic [6:0] af_latch_wdata,  // Latch write data
  input  wire logic       af_latch_we,     // Latch write strobe
  input  wire logic [6:0] af_dir_wdata,    // Direction write data
  input  wire logic       af_dir_we,       // Direction write strobe
  input  wire logic [6:0] af_digital_wdata,// 1 = pin digital
  input  wire logic       af_digital_we,   // Analog config strobe
  input  wire logic       cmp_off,         // Comparators turned off
  input  wire logic [6:0] cmp_out_en,      // Comparator drives pin
  input  wire logic [6:0] cmp_out_dat,     // Comparator outputs
  output logic      [6:0] analog_shared_port_read, // Read value
  output logic      [6:0] af_analog_sel,   // Pin routed to analog
  input  wire logic [6:0] af_pin_i,        // Pin levels
  output logic      [6:0] af_pin_o,        // Pin values
  output logic      [6:0] af_pin_oe,       // Drive enables
  // Low-power oscillator
  input  wire logic       lp_osc_en,       // Oscillator enabled
  output logic            lp_osc_pins_sel, // Pins on oscillator
  output logic            timer_ext_count_in, // Counter input
  // Capture/compare
  input  wire logic       ch2_pin_select_cfg, // 1 = port C pin 1
  input  wire logic       capcomp_ch1_pin_out,        // Channel 1 output
  input  wire logic       capcomp_ch1_pin_out_en,     // Channel 1 output mode
  output logic            capcomp_ch1_pin_cap_in,     // Channel 1 capture
  input  wire logic       capcomp_ch2_pin_out,        // Channel 2 output
  input  wire logic       capcomp_ch2_pin_out_en,     // Channel 2 output mode
  output logic            capcomp_ch2_pin_cap_in,     // Channel 2 capture
  // Sync serial port
  input  wire logic       ssp_en,          // Serial port enabled
  input  wire logic       ssp_i2c,         // 1 = I2C, 0 = SPI
  input  wire logic       ssp_i2c_smbus,   // Input buffer mode
  input  wire logic       spi_sck_out,     // SPI clock out
  input  wire logic       spi_sdo,         // SPI data out
  input  wire logic       i2c_scl_drv_low, // Pull clock low
  input  wire logic       i2c_sda_drv_low, // Pull data low
  output logic            ssp_sck_in,      // Clock to port
  output logic            ssp_sdi_in,      // Data to port
  output logic            i2c_in_mode_smbus, // Input buffer type
  // USART
  input  wire logic       usart_en,        // USART enabled
  input  wire logic       usart_sync,      // Synchronous mode
  input  wire logic       usart_tx,        // Transmit data
  input  wire logic       usart_clk_out,   // Sync master clock
  input  wire logic       usart_clk_out_en,// Drives clock pin
  input  wire logic       usart_dt_out_en, // Drives sync data
  output logic            usart_rx_in,     // Receive data
  output logic            usart_clk_in,    // Sync clock input
  // External memory interface
  input  wire logic       emi_en,          // Interface owns port E
  input  wire logic       emi_drive,       // Driving address/data
  input  wire logic [7:0] emi_ad_out,      // Address/data 15..8
  output logic      [7:0] emi_data_in,     // Data 15..8 in
  // Parallel slave port
  output logic            psp_rd_n,        // Read enable input
  output logic            psp_wr_n,        // Write enable input
  output logic            psp_cs_n         // Chip select input
);
  // Latch and direction registers
  logic [7:0] pc_latch;                    // Port C output latch
  logic [7:0] pin_direction_bit;           // Port C direction
  logic [7:0] pe_latch;                    // Port E output latch
  logic [7:0] pe_dir;                      // Port E direction
  logic [6:0] af_latch;                    // Analog port latch
  logic [6:0] af_dir;                      // Analog port direction
  logic [6:0] af_digital;                  // Analog configuration
  logic [7:0] pc_s, pe_s;                  // Synchronised pins
  logic [6:0] af_s;

  // Register writes, simple strobes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc_latch          <= pcef_pkg::LATCH_RST;
      pin_direction_bit <= pcef_pkg::DIR_RST;
      pe_latch          <= pcef_pkg::LATCH_RST;
      pe_dir            <= pcef_pkg::DIR_RST;
      af_latch          <= pcef_pkg::ALAT_RST;
      af_dir            <= pcef_pkg::ADIR_RST;
      af_digital        <= ~pcef_pkg::ANA_RST;
    end else begin
      if (pc_latch_we)   pc_latch          <= pc_latch_wdata;
      if (pc_dir_we)     pin_direction_bit <= pc_dir_wdata;
      if (pe_latch_we)   pe_latch          <= pe_latch_wdata;
      if (pe_dir_we)     pe_dir            <= pe_dir_wdata;
      // (R16) seven-bit analog port
      if (af_latch_we)   af_latch          <= af_latch_wdata;
      if (af_dir_we)     af_dir            <= af_dir_wdata;
      if (af_digital_we) af_digital        <= af_digital_wdata;
    end
  end

  // Pins cross from outside: two stages each
  pcef_sync #(.W(8)) u_sync_c (.clk_sys(clk_sys), .rst_n(rst_n),
    .async_in(pc_pin_i), .sync_out(pc_s));
  pcef_sync #(.W(8)) u_sync_e (.clk_sys(clk_sys), .rst_n(rst_n),
    .async_in(pe_pin_i), .sync_out(pe_s));
  pcef_sync #(.W(7)) u_sync_f (.clk_sys(clk_sys), .rst_n(rst_n),
    .async_in(af_pin_i), .sync_out(af_s));

  // Function ownership decode
  wire spi_on   = ssp_en && !ssp_i2c;
  wire i2c_on   = ssp_en && ssp_i2c;
  wire emi_on   = HAS_EMI && emi_en;       // (R14) variant gate
  wire capcomp_ch2_pin_on_c = ch2_pin_select_cfg;     // (R5) pin 1 of C
  wire capcomp_ch2_pin_on_e = !ch2_pin_select_cfg;    // (R6) bit 7 of E

  // Port C per-pin override tables
  logic [7:0] c_ovr_en, c_ovr_oe, c_ovr_dat, c_dis;
  always_comb begin
    c_ovr_en  = 8'h00;
    c_ovr_oe  = 8'h00;
    c_ovr_dat = 8'h00;
    c_dis     = 8'h00;
    // (R2) oscillator takes both pins
    c_dis[pcef_pkg::PC_OSC_OUT] = lp_osc_en;
    // (R3) input pin digital off
    c_dis[pcef_pkg::PC_OSC_IN]  = lp_osc_en;
    // (R5) channel two output on C1
    if (capcomp_ch2_pin_on_c && capcomp_ch2_pin_out_en && !pin_direction_bit[1]) begin
      c_ovr_en[1] = 1'b1; c_ovr_oe[1] = 1'b1; c_ovr_dat[1] = capcomp_ch2_pin_out;
    end
    // (R4) channel one output mode
    if (capcomp_ch1_pin_out_en && !pin_direction_bit[2]) begin
      c_ovr_en[2] = 1'b1; c_ovr_oe[2] = 1'b1; c_ovr_dat[2] = capcomp_ch1_pin_out;
    end
    // (R7) SPI clock out when bit clear
    if (spi_on && !pin_direction_bit[3]) begin
      c_ovr_en[3] = 1'b1; c_ovr_oe[3] = 1'b1; c_ovr_dat[3] = spi_sck_out;
    end
    // (R9) I2C open-drain clock and data
    if (i2c_on) begin
      c_ovr_en[3] = 1'b1; c_ovr_oe[3] = i2c_scl_drv_low;
      c_ovr_dat[3] = 1'b0;
      c_ovr_en[4] = 1'b1; c_ovr_oe[4] = i2c_sda_drv_low;
      c_ovr_dat[4] = 1'b0;
    end
    // (R8) SPI data out
    if (spi_on && !pin_direction_bit[5]) begin
      c_ovr_en[5] = 1'b1; c_ovr_oe[5] = 1'b1; c_ovr_dat[5] = spi_sdo;
    end
    // (R10) USART transmit or sync clock
    if (usart_en && (!usart_sync || usart_clk_out_en)) begin
      c_ovr_en[6] = 1'b1; c_ovr_oe[6] = 1'b1;
      c_ovr_dat[6] = usart_sync ? usart_clk_out : usart_tx;
    end
    // (R10) sync data output
    if (usart_en && usart_sync && usart_dt_out_en) begin
      c_ovr_en[7] = 1'b1; c_ovr_oe[7] = 1'b1; c_ovr_dat[7] = usart_tx;
    end
  end

  // Port E overrides: memory interface wins everything
  logic [7:0] e_ovr_en, e_ovr_oe, e_ovr_dat;
  always_comb begin
    e_ovr_en  = 8'h00;
    e_ovr_oe  = 8'h00;
    e_ovr_dat = 8'h00;
    // (R6) channel two on E7
    if (capcomp_ch2_pin_on_e && capcomp_ch2_pin_out_en && !pe_dir[7]) begin
      e_ovr_en[7] = 1'b1; e_ovr_oe[7] = 1'b1; e_ovr_dat[7] = capcomp_ch2_pin_out;
    end
    // (R13) memory overrides all
    if (emi_on) begin
      e_ovr_en  = 8'hFF;
      // (R12) drive address/data regardless of direction
      e_ovr_oe  = {8{emi_drive}};
      e_ovr_dat = emi_ad_out;
    end
  end

  // Per-bit pin cells
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bits
      pcef_port_bit u_c (.latch_bit(pc_latch[gi]),
        .dir_bit(pin_direction_bit[gi]), .ovr_en(c_ovr_en[gi]),
        .ovr_oe(c_ovr_oe[gi]), .ovr_dat(c_ovr_dat[gi]),
        .dis(c_dis[gi]), .pin_o(pc_pin_o[gi]), .pin_oe(pc_pin_oe[gi]));
      pcef_port_bit u_e (.latch_bit(pe_latch[gi]),
        .dir_bit(pe_dir[gi]), .ovr_en(e_ovr_en[gi]),
        .ovr_oe(e_ovr_oe[gi]), .ovr_dat(e_ovr_dat[gi]),
        .dis(1'b0), .pin_o(pe_pin_o[gi]), .pin_oe(pe_pin_oe[gi]));
    end
    for (gi = 0; gi < 7; gi++) begin : g_abits
      // (R17) comparator output claims pin
      wire cmp_drv = !cmp_off && cmp_out_en[gi] && gi != 0;
      pcef_port_bit u_f (.latch_bit(af_latch[gi]),
        .dir_bit(af_dir[gi]), .ovr_en(cmp_drv),
        .ovr_oe(1'b1), .ovr_dat(cmp_out_dat[gi]),
        .dis(af_analog_sel[gi] && !cmp_drv),
        .pin_o(af_pin_o[gi]), .pin_oe(af_pin_oe[gi]));
    end
  endgenerate

  // (R3) oscillator pins read zero while owned
  assign port_c_pin_read = pc_s & ~c_dis;
  assign port_e_pin_read = pe_s;
  assign lp_osc_pins_sel = lp_osc_en;
  assign timer_ext_count_in = lp_osc_en ? 1'b0 : pc_s[0];

  // (R4) capture inputs by direction
  assign capcomp_ch1_pin_cap_in = pin_direction_bit[2] ? pc_s[2] : 1'b0;
  assign capcomp_ch2_pin_cap_in = capcomp_ch2_pin_on_c ? (pin_direction_bit[1] ? pc_s[1] : 1'b0)
                                 : (pe_dir[7] ? pe_s[7] : 1'b0);
  // (R7) clock input when bit set, I2C always
  assign ssp_sck_in = (i2c_on || pin_direction_bit[3]) ? pc_s[3] : 1'b0;
  // (R8) SPI input data, I2C data in
  assign ssp_sdi_in = (i2c_on || pin_direction_bit[4]) ? pc_s[4] : 1'b0;
  // (R9) input buffer follows port mode
  assign i2c_in_mode_smbus = i2c_on && ssp_i2c_smbus;
  // (R10) receive and sync clock inputs
  // (R11) sync receive relies on software direction
  assign usart_rx_in  = usart_en ? pc_s[7] : 1'b1;
  assign usart_clk_in = usart_en && usart_sync ? pc_s[6] : 1'b0;
  // (R12) data only when receiving
  assign emi_data_in = (emi_on && !emi_drive) ? pe_s : 8'h00;
  // (R15) slave port controls; (R13) blocked by memory
  assign psp_rd_n = (pe_dir[0] && !emi_on) ? pe_s[0] : 1'b1;
  assign psp_wr_n = (pe_dir[1] && !emi_on) ? pe_s[1] : 1'b1;
  assign psp_cs_n = (pe_dir[2] && !emi_on) ? pe_s[2] : 1'b1;

  // (R18) analog pins read zero
  assign af_analog_sel = ~af_digital & pcef_pkg::ANA_RST;
  // (R17) pins 6..3 need comparators off
  assign analog_shared_port_read = af_s & ~af_analog_sel &
    ~(cmp_off ? 7'h00 : pcef_pkg::CMP_RD_MASK);

  // AST_OSC_PINS: oscillator pins never driven
  AST_OSC_PINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lp_osc_en |-> pc_pin_oe[1:0] == 2'b00 && port_c_pin_read[1:0] == 2'b00)
    else $error("oscillator pin not released"); // (R2)
  AST_EMI_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emi_on && emi_drive |-> pe_pin_o == emi_ad_out && pe_pin_oe == 8'hFF)
    else $error("memory interface not driving"); // (R13)
  // Direction written in the same cycle counts as the new direction
  AST_LATCH_DRV: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pc_latch_we && !capcomp_ch1_pin_out_en &&
    (pc_dir_we ? !pc_dir_wdata[2] : !pin_direction_bit[2])
    ##1 !capcomp_ch1_pin_out_en && !pc_dir_we |-> pc_pin_o[2] ==
    $past(pc_latch_wdata[2]) && pc_pin_oe[2])
    else $error("latch not driven"); // (R1)
  // (R13) slave port controls idle under memory
  AST_PSP_BLOCKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emi_on |-> {psp_cs_n, psp_wr_n, psp_rd_n} == 3'b111)
    else $error("slave port seen under memory"); // (R13)
  // (R12) receiving: pins released, data passed in
  AST_EMI_RECV: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emi_on && !emi_drive |-> pe_pin_oe == 8'h00 && emi_data_in == pe_s)
    else $error("memory receive path wrong"); // (R12)
  AST_RESET_ZERO: assert property (@(posedge clk_sys)
    !rst_n ##1 rst_n && !af_digital_we |->
    analog_shared_port_read[6:1] == 6'h00)
    else $error("analog pins read nonzero"); // (R18)
endmodule // pcef_pin_mux

// [sim/pcef_board.sv]
// Board model that drives the multiplexed package pins
`timescale 1ns/1ps
module pcef_board #(
  parameter int W = 8                 // Pins on this port
) (
  input  wire logic [W-1:0] pin_o,    // Device pin values
  input  wire logic [W-1:0] pin_oe,   // Device drive enables
  input  wire logic [W-1:0] drv,      // Level the board drives
  output logic      [W-1:0] pin_i     // Resolved pin levels
);
  // Device wins where it drives; board level where it releases
  assign pin_i = (pin_o & pin_oe) | (drv & ~pin_oe);
endmodule // pcef_board

// [sim/pcef_pin_mux_tb_top.sv]
// Self-checking bench for the port C/E/F pin multiplexer
`timescale 1ns/1ps
module pcef_pin_mux_tb_top;
  // Clock, reset and board-driven levels
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] c_drv = 8'hFF, e_drv = 8'hFF;
  logic [6:0] f_drv = 7'h7F;
  // Design inputs
  logic [7:0] pc_latch_wdata, pc_dir_wdata, pe_latch_wdata, pe_dir_wdata;
  logic [7:0] emi_ad_out;
  logic [6:0] af_latch_wdata, af_dir_wdata, af_digital_wdata;
  logic [6:0] cmp_out_en, cmp_out_dat;
  logic       pc_latch_we, pc_dir_we, pe_latch_we, pe_dir_we;
  logic       af_latch_we, af_dir_we, af_digital_we, cmp_off;
  logic       lp_osc_en, ch2_pin_select_cfg, capcomp_ch1_pin_out, capcomp_ch1_pin_out_en;
  logic       capcomp_ch2_pin_out, capcomp_ch2_pin_out_en, ssp_en, ssp_i2c, ssp_i2c_smbus;
  logic       spi_sck_out, spi_sdo, i2c_scl_drv_low, i2c_sda_drv_low;
  logic       usart_en, usart_sync, usart_tx, usart_clk_out;
  logic       usart_clk_out_en, usart_dt_out_en, emi_en, emi_drive;
  // Design outputs and resolved pins
  wire  [7:0] pc_pin_i, pe_pin_i;
  wire  [6:0] af_pin_i;
  logic [7:0] port_c_pin_read, pc_pin_o, pc_pin_oe, emi_data_in;
  logic [7:0] port_e_pin_read, pe_pin_o, pe_pin_oe;
  logic [6:0] analog_shared_port_read, af_analog_sel, af_pin_o, af_pin_oe;
  logic       lp_osc_pins_sel, timer_ext_count_in, capcomp_ch1_pin_cap_in;
  logic       capcomp_ch2_pin_cap_in, ssp_sck_in, ssp_sdi_in, i2c_in_mode_smbus;
  logic       usart_rx_in, usart_clk_in, psp_rd_n, psp_wr_n, psp_cs_n;
  int         fails = 0;              // Mismatches seen
  int         num_checks = 0;         // Comparisons made

  // Device under test, every port by its own name
  pcef_pin_mux #(.HAS_EMI(1'b1)) i_pcef_pin_mux (.*);
  // Board on each of the three ports
  pcef_board #(.W(8)) i_pcef_board_c (.pin_o(pc_pin_o),
    .pin_oe(pc_pin_oe), .drv(c_drv), .pin_i(pc_pin_i));
  pcef_board #(.W(8)) i_pcef_board_e (.pin_o(pe_pin_o),
    .pin_oe(pe_pin_oe), .drv(e_drv), .pin_i(pe_pin_i));
  pcef_board #(.W(7)) i_pcef_board_f (.pin_o(af_pin_o),
    .pin_oe(af_pin_oe), .drv(f_drv), .pin_i(af_pin_i));

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  // Compare and count; values in hex on a mismatch
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait whole cycles, landing on a falling edge
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One-cycle write: 0 port C, 1 port E, 2 analog port, 3 analog cfg
  task automatic wr(input int p, input logic [7:0] l, d);
    @(negedge clk_sys);
    case (p)
      0: {pc_latch_wdata, pc_dir_wdata, pc_latch_we, pc_dir_we} = {l, d, 2'b11};
      1: {pe_latch_wdata, pe_dir_wdata, pe_latch_we, pe_dir_we} = {l, d, 2'b11};
      2: {af_latch_wdata, af_dir_wdata, af_latch_we, af_dir_we} =
           {l[6:0], d[6:0], 2'b11};
      default: {af_digital_wdata, af_digital_we} = {l[6:0], 1'b1};
    endcase
    @(negedge clk_sys);
    {pc_latch_we, pc_dir_we, pe_latch_we, pe_dir_we} = '0;
    {af_latch_we, af_dir_we, af_digital_we} = '0;
  endtask

  // Verdict and end of run; also reached by the watchdog
  task automatic finish_test;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    fails++;
    finish_test();
  end

  // Main sequence
  initial begin
    {pc_latch_wdata, pc_dir_wdata, pe_latch_wdata, pe_dir_wdata} = '0;
    {af_latch_wdata, af_dir_wdata, af_digital_wdata, emi_ad_out} = '0;
    {cmp_out_en, cmp_out_dat, pc_latch_we, pc_dir_we, pe_latch_we} = '0;
    {pe_dir_we, af_latch_we, af_dir_we, af_digital_we, cmp_off} = '0;
    {lp_osc_en, ch2_pin_select_cfg, capcomp_ch1_pin_out, capcomp_ch1_pin_out_en, capcomp_ch2_pin_out} = '0;
    {capcomp_ch2_pin_out_en, ssp_en, ssp_i2c, ssp_i2c_smbus, spi_sck_out} = '0;
    {spi_sdo, i2c_scl_drv_low, i2c_sda_drv_low, usart_en, usart_sync} = '0;
    {usart_tx, usart_clk_out, usart_clk_out_en, usart_dt_out_en} = '0;
    {emi_en, emi_drive} = '0;
    wt(12);
    rst_n = 1'b1;
    wt(1);
    // pins released, analog pins read zero
    check({pc_pin_oe, pe_pin_oe}, 16'h0000);
    check({1'b0, af_pin_oe, 1'b0, af_analog_sel}, 16'h007E);
    check(analog_shared_port_read & 7'h7E, 16'h0000);
    $display("test reset done");
    // latch drives, every pin enabled
    wr(0, 8'hA5, 8'h00);
    check({pc_pin_o, pc_pin_oe}, 16'hA5FF);
    // Oscillator takes both pins whatever the direction says
    lp_osc_en = 1'b1;
    wt(1);
    check({pc_pin_oe & 8'h03, 7'h00, lp_osc_pins_sel}, 16'h0001);
    wr(0, 8'hA5, 8'hFF);
    c_drv = 8'h5B;
    wt(3);
    check({port_c_pin_read & 8'h03, 7'h00, timer_ext_count_in}, 0);
    lp_osc_en = 1'b0;
    wt(3);
    check({port_c_pin_read, 7'h00, timer_ext_count_in}, 16'h5B01);
    // Capture/compare outputs over latch data, channel two routing
    wr(0, 8'h00, 8'h00);
    {capcomp_ch1_pin_out_en, capcomp_ch1_pin_out, capcomp_ch2_pin_out_en, capcomp_ch2_pin_out} = 4'hF;
    ch2_pin_select_cfg = 1'b1;
    wt(1);
    check(pc_pin_o & 8'h06, 16'h0006);
    ch2_pin_select_cfg = 1'b0;
    wr(1, 8'h00, 8'h7F);
    check({pc_pin_o[1], pe_pin_o[7], pe_pin_oe[7]}, 16'h0003);
    wr(0, 8'h00, 8'h04);
    c_drv = 8'h04;
    wt(3);
    check({pc_pin_oe[2], capcomp_ch1_pin_cap_in}, 16'h0001);
    {capcomp_ch1_pin_out_en, capcomp_ch2_pin_out_en} = 2'b00;
    $display("test port C done");
    // SPI clock and data out, then clock and data in
    {ssp_en, spi_sck_out, spi_sdo} = 3'b111;
    wr(0, 8'h00, 8'h10);
    c_drv = 8'h18;
    wt(3);
    check({pc_pin_o & 8'h28, 7'h00, ssp_sdi_in}, 16'h2801);
    wr(0, 8'h00, 8'h18);
    wt(3);
    check({pc_pin_oe[3], ssp_sck_in}, 16'h0001);
    // I2C open-drain low beats latch high; input mode follows port
    wr(0, 8'h18, 8'h00);
    {ssp_i2c, ssp_i2c_smbus, i2c_scl_drv_low} = 3'b111;
    wt(1);
    check({pc_pin_o[3], pc_pin_oe[3], pc_pin_oe[4]}, 16'h0002);
    check(i2c_in_mode_smbus, 16'h0001);
    {ssp_en, ssp_i2c, i2c_scl_drv_low} = 3'b000;
    // receive pin set to input before use
    wr(0, 8'h00, 8'h80);
    {usart_en, usart_tx} = 2'b11;
    c_drv = 8'h00;
    wt(3);
    check({pc_pin_o[6], pc_pin_oe[6], usart_rx_in}, 16'h0006);
    usart_sync = 1'b1;
    wr(0, 8'h00, 8'hC0);
    c_drv = 8'h40;
    wt(3);
    check({pc_pin_oe[6], usart_clk_in}, 16'h0001);
    {usart_en, usart_sync} = 2'b00;
    $display("test serial done");
    // Memory interface beats latch data on port E
    wr(1, 8'hFF, 8'h00);
    {emi_en, emi_drive, emi_ad_out} = {2'b11, 8'h3C};
    wt(1);
    check({pe_pin_o, pe_pin_oe}, 16'h3CFF);
    emi_drive = 1'b0;
    wr(1, 8'hFF, 8'hFF);
    e_drv = 8'hC2;
    wt(3);
    check({pe_pin_oe, emi_data_in}, 16'h00C2);
    check(capcomp_ch2_pin_cap_in, 16'h0001);
    check({psp_cs_n, psp_wr_n, psp_rd_n}, 16'h0007);
    emi_en = 1'b0;
    wt(3);
    check({psp_cs_n, psp_wr_n, psp_rd_n}, 16'h0002);
    check(port_e_pin_read, 16'h00C2);
    $display("test port E done");
    // Analog port as digital I/O, comparators gate pins 6..3
    wr(3, 8'h7F, 8'h00);
    cmp_off = 1'b1;
    wr(2, 8'h05, 8'h78);
    f_drv = 7'h50;
    wt(3);
    check({1'b0, af_pin_oe, 1'b0, af_pin_o & 7'h07}, 16'h0705);
    check(analog_shared_port_read & 7'h78, 16'h0050);
    cmp_off = 1'b0;
    {cmp_out_en, cmp_out_dat} = {7'h02, 7'h02};
    wt(1);
    check(analog_shared_port_read & 7'h78, 16'h0000);
    check({af_pin_o[1], af_pin_oe[1]}, 16'h0003);
    $display("test analog port done");
    finish_test();
  end
endmodule // pcef_pin_mux_tb_top
